// >>> rtl/tlh_pkg.sv
// Shared constants and types for the trigger line handshake block
package tlh_pkg;

    // Trigger link geometry
    localparam int TLH_LINES = 6;
    localparam int TLH_LINE_W = 3;

    // Register byte offsets
    localparam logic [11:0] TLH_ADDR_CTRL = 12'h000;
    localparam logic [11:0] TLH_ADDR_LINES = 12'h004;
    localparam logic [11:0] TLH_ADDR_CFG = 12'h008;
    localparam logic [11:0] TLH_ADDR_COUNT = 12'h00C;
    localparam logic [11:0] TLH_ADDR_STATUS = 12'h010;

    // CTRL fields (write-only strobes)
    localparam int TLH_CTRL_START = 0;
    localparam int TLH_CTRL_ABORT = 1;

    // LINES fields
    localparam int TLH_LINES_IN_LSB = 0;
    localparam int TLH_LINES_OUT_LSB = 4;

    // CFG fields; event bit order is source, delay, measure
    localparam int TLH_CFG_TLINK = 0;
    localparam int TLH_CFG_BYPASS = 1;
    localparam int TLH_CFG_IN_EV_LSB = 2;
    localparam int TLH_CFG_OUT_EV_LSB = 5;

    // STATUS fields
    localparam int TLH_STAT_STATE_LSB = 0;
    localparam int TLH_STAT_BUSY = 3;
    localparam int TLH_STAT_DONE = 4;
    localparam int TLH_STAT_PEND = 5;
    localparam int TLH_STAT_REMAIN_LSB = 16;

    // Reset values
    localparam logic [2:0] TLH_RST_IN_LINE = 3'h1;
    localparam logic [2:0] TLH_RST_OUT_LINE = 3'h2;
    localparam logic [2:0] TLH_RST_IN_EV = 3'h1;
    localparam logic [2:0] TLH_RST_OUT_EV = 3'h0;
    localparam logic [15:0] TLH_RST_COUNT = 16'h0001;

    // Output pulse timing
    localparam int TLH_CLK_NS = 40;
    localparam int TLH_PULSE_NS = 10000;
    localparam int TLH_PULSE_CYC = (TLH_PULSE_NS + TLH_CLK_NS - 1) / TLH_CLK_NS;

    // Sequencer actions
    localparam logic [1:0] TLH_ACT_SRC = 2'h0;
    localparam logic [1:0] TLH_ACT_DLY = 2'h1;
    localparam logic [1:0] TLH_ACT_AFTER_MEASURE_OUT_EVENT = 2'h2;

    // Gray coded along idle, wait/do source, delay, measure
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_WSRC = 3'h1,
        ST_DSRC = 3'h3,
        ST_WDLY = 3'h2,
        ST_DDLY = 3'h6,
        ST_WMEAS = 3'h7,
        ST_DMEAS = 3'h5
    } tlh_state_e;

    // Line number 1..6 to one-hot; any other value selects nothing
    function automatic logic [TLH_LINES-1:0] tlh_line_mask(
        input logic [TLH_LINE_W-1:0] line
    );
        tlh_line_mask = '0;
        for (int i = 0; i < TLH_LINES; i++)
        begin
            if (line == TLH_LINE_W'(i + 1))
                tlh_line_mask[i] = 1'b1;
        end
    endfunction

endpackage

// >>> rtl/tlh_pulse_gen.sv
// Active-low output trigger pulse generator on a selectable line
`timescale 1ns/1ns
module tlh_pulse_gen
    import tlh_pkg::*;
#(
    parameter int PULSE_CYC = TLH_PULSE_CYC
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Request
    input wire logic fire,
    input wire logic [TLH_LINE_W-1:0] line,
    // Line drive
    output logic [TLH_LINES-1:0] line_oe,
    output logic busy
);
    localparam int CW = $clog2(PULSE_CYC + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic [TLH_LINES-1:0] oe;
    } tlh_pulse_s;

    tlh_pulse_s r_ff;
    tlh_pulse_s nxt_r;

    // A new fire restarts the pulse rather than queueing a second one
    always_comb
    begin
        nxt_r = r_ff;
        if (fire)
        begin
            nxt_r.oe = tlh_line_mask(line);
            nxt_r.cnt = CW'(PULSE_CYC - 1);
        end
        else if (r_ff.cnt != '0)
            nxt_r.cnt = r_ff.cnt - CW'(1);
        else
            nxt_r.oe = '0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r_ff <= '0;
        else
            r_ff <= nxt_r;
    end

    assign line_oe = r_ff.oe;
    assign busy = |r_ff.oe;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    pulse_start_a: assert property (
        fire |=> (r_ff.cnt == CW'(PULSE_CYC - 1))
            && (line_oe == tlh_line_mask($past(line))))
        else $error("pulse did not start with full width");

    pulse_hold_a: assert property (
        (busy && r_ff.cnt != '0 && !fire) |=>
            busy && (r_ff.cnt == $past(r_ff.cnt) - CW'(1)))
        else $error("pulse ended early or count stuck");

endmodule // tlh_pulse_gen

// >>> rtl/tlh_trigger_link.sv
// Trigger link sequencer with APB registers and open-drain lines
//
// How it works
// - Output line defaults to 2, input line to 1; both writable.
// - Falling edge on selected input satisfies trigger-link event detection.
// - Detector triggers on falling edge; partner must drive high-to-low.
// - With trigger link as source, output pulse follows each action whose output event is enabled.
// - With trigger link as source and the measure input event enabled, loop waits for input before measure.
// - After measuring, pulse the output, then wait for next input.
// - Only measure output event set: pulses follow measure actions only.
// - Wait-measure-pulse loop repeats for the programmed trigger count.
// - With trigger link as source, enabled detectors stall for input; others pass through.
// - All output events are disabled after reset.
`timescale 1ns/1ns
module tlh_trigger_link
    import tlh_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int PULSE_CYC = TLH_PULSE_CYC
)
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Trigger link lines, open drain
    input wire logic [TLH_LINES-1:0] tl_in,
    output logic [TLH_LINES-1:0] tl_out,
    output logic [TLH_LINES-1:0] tl_oe,
    // Action handshake with the source/measure engine
    output logic act_go,
    output logic [1:0] act_sel,
    input wire logic act_done,
    // Status
    output logic busy
);
    typedef struct packed {
        tlh_state_e state;
        logic [TLH_LINE_W-1:0] in_line;
        logic [TLH_LINE_W-1:0] out_line;
        logic src_tlink;
        logic bypass_once;
        logic [2:0] in_ev;
        logic [2:0] out_ev;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] remain;
        logic first;
        logic pend;
        logic done;
        logic [TLH_LINES-1:0] lines_q;
        logic act_go;
        logic [1:0] act_sel;
        logic pulse_go;
        logic [31:0] prdata;
        logic lines_seen;
        logic cfg_seen;
    } tlh_core_s;

    tlh_core_s r_ff;
    tlh_core_s nxt_r;

    logic wr_en;
    logic hit;
    logic fall_sel;
    logic start_w;
    logic abort_w;
    logic pulse_busy;

    // Detector passes when trigger link is not the source, its event is
    // off, or an input edge is pending
    function automatic logic det_pass(
        input logic tlink,
        input logic en,
        input logic pend
    );
        det_pass = !tlink || !en || pend;
    endfunction

    assign hit = (paddr == TLH_ADDR_CTRL) || (paddr == TLH_ADDR_LINES)
        || (paddr == TLH_ADDR_CFG) || (paddr == TLH_ADDR_COUNT)
        || (paddr == TLH_ADDR_STATUS);
    assign wr_en = psel && penable && pwrite && hit;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign start_w = wr_en && (paddr == TLH_ADDR_CTRL)
        && pwdata[TLH_CTRL_START];
    assign abort_w = wr_en && (paddr == TLH_ADDR_CTRL)
        && pwdata[TLH_CTRL_ABORT];

    // Inputs are synchronous; previous sample of every line is kept so a
    // change of the selected line cannot fake an edge on the new one
    assign fall_sel = |(r_ff.lines_q & ~tl_in
        & tlh_line_mask(r_ff.in_line));

    always_comb
    begin
        logic consume;
        logic done_set;
        logic [31:0] rd;
        nxt_r = r_ff;
        consume = 1'b0;
        done_set = 1'b0;
        rd = '0;
        nxt_r.act_go = 1'b0;
        nxt_r.pulse_go = 1'b0;
        nxt_r.lines_q = tl_in;

        case (r_ff.state)
            ST_IDLE:
                nxt_r.state = ST_IDLE;
            ST_WSRC:
            begin
                if ((r_ff.bypass_once && r_ff.first)
                    || det_pass(r_ff.src_tlink, r_ff.in_ev[0], r_ff.pend))
                begin
                    consume = r_ff.src_tlink && r_ff.in_ev[0]
                        && !(r_ff.bypass_once && r_ff.first);
                    nxt_r.first = 1'b0;
                    nxt_r.state = ST_DSRC;
                    nxt_r.act_go = 1'b1;
                    nxt_r.act_sel = TLH_ACT_SRC;
                end
            end
            ST_DSRC:
            begin
                if (act_done)
                begin
                    nxt_r.pulse_go = r_ff.src_tlink && r_ff.out_ev[0];
                    nxt_r.state = ST_WDLY;
                end
            end
            ST_WDLY:
            begin
                if (det_pass(r_ff.src_tlink, r_ff.in_ev[1], r_ff.pend))
                begin
                    consume = r_ff.src_tlink && r_ff.in_ev[1];
                    nxt_r.state = ST_DDLY;
                    nxt_r.act_go = 1'b1;
                    nxt_r.act_sel = TLH_ACT_DLY;
                end
            end
            ST_DDLY:
            begin
                if (act_done)
                begin
                    nxt_r.pulse_go = r_ff.src_tlink && r_ff.out_ev[1];
                    nxt_r.state = ST_WMEAS;
                end
            end
            ST_WMEAS:
            begin
                if (det_pass(r_ff.src_tlink, r_ff.in_ev[2], r_ff.pend))
                begin
                    consume = r_ff.src_tlink && r_ff.in_ev[2];
                    nxt_r.state = ST_DMEAS;
                    nxt_r.act_go = 1'b1;
                    nxt_r.act_sel = TLH_ACT_AFTER_MEASURE_OUT_EVENT;
                end
            end
            ST_DMEAS:
            begin
                if (act_done)
                begin
                    nxt_r.pulse_go = r_ff.src_tlink && r_ff.out_ev[2];
                    if (r_ff.remain <= CNT_W'(1))
                    begin
                        nxt_r.remain = '0;
                        nxt_r.state = ST_IDLE;
                        done_set = 1'b1;
                    end
                    else
                    begin
                        nxt_r.remain = r_ff.remain - CNT_W'(1);
                        nxt_r.state = ST_WSRC;
                    end
                end
            end
            default:
                nxt_r.state = ST_IDLE;
        endcase

        // A pending edge is consumed by a waiting detector or cleared by a start
        // write; a new edge in the same cycle survives the clear
        nxt_r.pend = (r_ff.pend && !consume && !start_w) || fall_sel;

        // Register writes take effect in the access phase
        if (wr_en)
        begin
            case (paddr)
                TLH_ADDR_LINES:
                begin
                    nxt_r.in_line = pwdata[TLH_LINES_IN_LSB +: TLH_LINE_W];
                    nxt_r.out_line = pwdata[TLH_LINES_OUT_LSB +: TLH_LINE_W];
                    nxt_r.lines_seen = 1'b1;
                end
                TLH_ADDR_CFG:
                begin
                    nxt_r.src_tlink = pwdata[TLH_CFG_TLINK];
                    nxt_r.bypass_once = pwdata[TLH_CFG_BYPASS];
                    nxt_r.in_ev = pwdata[TLH_CFG_IN_EV_LSB +: 3];
                    nxt_r.out_ev = pwdata[TLH_CFG_OUT_EV_LSB +: 3];
                    nxt_r.cfg_seen = 1'b1;
                end
                TLH_ADDR_COUNT:
                    nxt_r.count = pwdata[CNT_W-1:0];
                default:
                    nxt_r.count = nxt_r.count;
            endcase
        end

        // Abort wins over start; a zero count runs once
        if (abort_w)
        begin
            nxt_r.state = ST_IDLE;
            nxt_r.act_go = 1'b0;
            nxt_r.pulse_go = 1'b0;
        end
        else if (start_w && r_ff.state == ST_IDLE)
        begin
            nxt_r.state = ST_WSRC;
            nxt_r.first = 1'b1;
            nxt_r.remain = (r_ff.count == '0) ? CNT_W'(1) : r_ff.count;
        end

        // Done is sticky, write one to clear, a new completion wins
        nxt_r.done = (r_ff.done && !(wr_en && paddr == TLH_ADDR_STATUS
            && pwdata[TLH_STAT_DONE])) || done_set;

        // Read data is captured in the setup phase and held for access
        case (paddr)
            TLH_ADDR_LINES:
            begin
                rd[TLH_LINES_IN_LSB +: TLH_LINE_W] = r_ff.in_line;
                rd[TLH_LINES_OUT_LSB +: TLH_LINE_W] = r_ff.out_line;
            end
            TLH_ADDR_CFG:
            begin
                rd[TLH_CFG_TLINK] = r_ff.src_tlink;
                rd[TLH_CFG_BYPASS] = r_ff.bypass_once;
                rd[TLH_CFG_IN_EV_LSB +: 3] = r_ff.in_ev;
                rd[TLH_CFG_OUT_EV_LSB +: 3] = r_ff.out_ev;
            end
            TLH_ADDR_COUNT:
                rd[CNT_W-1:0] = r_ff.count;
            TLH_ADDR_STATUS:
            begin
                rd[TLH_STAT_STATE_LSB +: 3] = r_ff.state;
                rd[TLH_STAT_BUSY] = (r_ff.state != ST_IDLE);
                rd[TLH_STAT_DONE] = r_ff.done;
                rd[TLH_STAT_PEND] = r_ff.pend;
                rd[TLH_STAT_REMAIN_LSB +: CNT_W] = r_ff.remain;
            end
            default:
                rd = '0;
        endcase
        if (psel && !penable)
            nxt_r.prdata = rd;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_ff <= '0;
            r_ff.state <= ST_IDLE;
            r_ff.in_line <= TLH_RST_IN_LINE;
            r_ff.out_line <= TLH_RST_OUT_LINE;
            r_ff.in_ev <= TLH_RST_IN_EV;
            r_ff.out_ev <= TLH_RST_OUT_EV;
            r_ff.count <= CNT_W'(TLH_RST_COUNT);
            r_ff.lines_q <= '1;
        end
        else
            r_ff <= nxt_r;
    end

    // Lines are only ever pulled low, never driven high
    tlh_pulse_gen #(
        .PULSE_CYC(PULSE_CYC)
    ) u_pulse (
        .pclk(pclk),
        .presetn(presetn),
        .fire(r_ff.pulse_go),
        .line(r_ff.out_line),
        .line_oe(tl_oe),
        .busy(pulse_busy)
    );

    assign tl_out = '0;
    assign prdata = r_ff.prdata;
    assign act_go = r_ff.act_go;
    assign act_sel = r_ff.act_sel;
    assign busy = (r_ff.state != ST_IDLE) || pulse_busy;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence after_measure_out_event_done_s;
        r_ff.state == ST_DMEAS && act_done && !abort_w;
    endsequence

    sequence pulse_out_s;
        r_ff.pulse_go ##1 (tl_oe == tlh_line_mask(r_ff.out_line));
    endsequence

    line_default_a: assert property (
        !r_ff.lines_seen |-> r_ff.in_line == TLH_RST_IN_LINE
            && r_ff.out_line == TLH_RST_OUT_LINE)
        else $error("line selection lost its default");

    no_pulse_reset_a: assert property (
        !r_ff.cfg_seen |-> !r_ff.pulse_go && tl_oe == '0)
        else $error("output pulse before any configuration");

    edge_catch_a: assert property (
        (r_ff.lines_q[r_ff.in_line - 3'h1] && !tl_in[r_ff.in_line - 3'h1]
            && r_ff.in_line >= 3'h1 && r_ff.in_line <= 3'h6) |=> r_ff.pend)
        else $error("falling edge on input line not caught");

    after_measure_out_event_wait_a: assert property (
        (r_ff.state == ST_WMEAS && r_ff.src_tlink && r_ff.in_ev[2]
            && !r_ff.pend && !abort_w) |=> r_ff.state == ST_WMEAS && !act_go)
        else $error("measure started without an input trigger");

    after_measure_out_event_pulse_a: assert property (
        (after_measure_out_event_done_s and (r_ff.src_tlink && r_ff.out_ev[2]))
            |=> pulse_out_s)
        else $error("no output pulse after measurement");

    src_quiet_a: assert property (
        (r_ff.state inside {ST_DSRC, ST_DDLY} && act_done
            && r_ff.out_ev[1:0] == 2'h0) |=> !r_ff.pulse_go)
        else $error("pulse after source or delay while disabled");

    loop_count_a: assert property (
        (after_measure_out_event_done_s and (r_ff.remain > CNT_W'(1))) |=>
            r_ff.state == ST_WSRC && r_ff.remain == $past(r_ff.remain) - 1'b1)
        else $error("trigger loop count not stepped");

    loop_end_a: assert property (
        (after_measure_out_event_done_s and (r_ff.remain <= CNT_W'(1))) |=>
            r_ff.state == ST_IDLE && r_ff.done)
        else $error("trigger loop did not finish at count");

    pass_thru_a: assert property (
        (r_ff.state == ST_WDLY && !(r_ff.src_tlink && r_ff.in_ev[1])
            && !abort_w) |=> r_ff.state == ST_DDLY && act_go
            && act_sel == TLH_ACT_DLY)
        else $error("disabled detector stalled the loop");

endmodule // tlh_trigger_link

// >>> tb/tlh_scanner_model.sv
// Behavioural switching scanner facing the trigger lines
`timescale 1ns/1ns
module tlh_scanner_model
#(
    parameter int NCH = 10,
    parameter int SETTLE = 5,
    parameter int PW = 3
)
(
    // Clock, reset and scan start
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    // Line indices, 0 is line 1
    input wire logic [2:0] in_idx,
    input wire logic [2:0] out_idx,
    // Wire levels and own pull-down
    input wire logic [5:0] lvl,
    output logic [5:0] oe,
    output int closed
);
    // Sampling only on the clock keeps a glitch-free view of the shared wire
    task automatic wait_edge();
        logic p;
        p = lvl[in_idx];
        forever
        begin
            @(posedge pclk);
            if (p && !lvl[in_idx])
                break;
            p = lvl[in_idx];
        end
    endtask

    initial
    begin
        oe = '0;
        closed = 0;
        forever
        begin
            @(posedge pclk);
            if (start && presetn)
            begin
                for (int c = 0; c < NCH; c++)
                begin
                    if (c > 0)
                        wait_edge();
                    closed <= c + 1;
                    repeat (SETTLE) @(posedge pclk);
                    oe[out_idx] <= 1'b1;
                    repeat (PW) @(posedge pclk);
                    oe[out_idx] <= 1'b0;
                end
            end
        end
    end
endmodule // tlh_scanner_model

// >>> tb/tlh_trigger_link_tb.sv
// Self-checking bench for the trigger line handshake block
`timescale 1ns/1ns
module tlh_trigger_link_tb
    import tlh_pkg::*;
;
    localparam int PCYC = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [5:0] tl_out, tl_oe, sc_oe, tb_oe, lvl, oe_q;
    logic act_go, act_done, sc_start, dut_busy;
    logic [1:0] act_sel, done_sel;
    logic [2:0] done_sh, sc_in_idx, sc_out_idx;
    int error_cnt, compares, wid, closed;
    int pulses[6];
    int pk[3];
    logic [1:0] acts[$];

    // Open-drain wire with pull-up
    assign lvl = ~(tl_oe | sc_oe | tb_oe);

    tlh_trigger_link #(.CNT_W(16), .PULSE_CYC(PCYC)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .tl_in(lvl), .tl_out(tl_out),
        .tl_oe(tl_oe), .act_go(act_go), .act_sel(act_sel),
        .act_done(act_done), .busy(dut_busy));

    tlh_scanner_model #(.NCH(10), .SETTLE(5), .PW(3)) scan_u (
        .pclk(pclk), .presetn(presetn), .start(sc_start),
        .in_idx(sc_in_idx), .out_idx(sc_out_idx), .lvl(lvl), .oe(sc_oe),
        .closed(closed));

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string m);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s got %0h exp %0h", $time, m,
                got, exp);
        end
    endtask

    // Action engine answers four cycles after each start
    always @(posedge pclk)
    begin
        if (!presetn)
        begin
            done_sh <= '0;
            act_done <= 1'b0;
            done_sel <= '0;
            oe_q <= '0;
            wid <= 0;
        end
        else
        begin
            done_sh <= {done_sh[1:0], act_go};
            act_done <= done_sh[2];
            if (act_go)
                acts.push_back(act_sel);
            if (act_done)
                done_sel <= act_sel;
            oe_q <= tl_oe;
            wid <= (|tl_oe) ? wid + 1 : 0;
            if (!(|tl_oe) && (|oe_q))
                chk(wid, PCYC, "pulse width");
            for (int i = 0; i < 6; i++)
            begin
                if (tl_oe[i] && !oe_q[i])
                begin
                    pulses[i]++;
                    pk[done_sel]++;
                end
            end
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x,
        input string m);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, x, m);
    endtask

    task automatic clr();
        acts.delete();
        pulses = '{default: 0};
        pk = '{default: 0};
    endtask

    function automatic int cnt(input logic [1:0] s);
        cnt = 0;
        foreach (acts[i])
            if (acts[i] === s)
                cnt++;
    endfunction

    task automatic wait_done();
        logic [31:0] q;
        logic e;
        int n;
        n = 0;
        do
        begin
            apb(1'b0, TLH_ADDR_STATUS, 32'h0, q, e);
            n++;
        end while (q[TLH_STAT_DONE] !== 1'b1 && n < 500);
        chk(q[TLH_STAT_DONE], 32'h1, "done flag");
        wr(TLH_ADDR_STATUS, 32'h0000_0010);
    endtask

    task automatic reset_regs();
        logic [31:0] q;
        logic e;
        rd(TLH_ADDR_LINES, 32'h0000_0021, "line select");
        rd(TLH_ADDR_CFG, 32'h0000_0004, "config");
        rd(TLH_ADDR_COUNT, 32'h0000_0001, "count");
        apb(1'b0, 12'h014, 32'h0, q, e);
        chk(e, 32'h1, "unmapped error");
    endtask

    task automatic imm_run();
        clr();
        wr(TLH_ADDR_COUNT, 32'h0000_0003);
        wr(TLH_ADDR_CTRL, 32'h0000_0001);
        wait_done();
        chk(acts.size(), 32'h9, "action count");
        for (int i = 0; i < 9; i++)
            chk(acts[i], i % 3, "action order");
        chk(pulses.sum(), 32'h0, "pulse after reset");
    endtask

    task automatic detectors();
        clr();
        wr(TLH_ADDR_COUNT, 32'h0000_0001);
        wr(TLH_ADDR_CFG, 32'h0000_006D);
        tb_oe[0] <= 1'b1;
        wr(TLH_ADDR_CTRL, 32'h0000_0001);
        repeat (10) @(posedge pclk);
        chk(acts.size(), 32'h0, "source stall");
        tb_oe[0] <= 1'b0;
        repeat (10) @(posedge pclk);
        chk(acts.size(), 32'h0, "rising edge ignored");
        tb_oe[0] <= 1'b1;
        repeat (12) @(posedge pclk);
        chk(acts.size(), 32'h1, "delay stall");
        tb_oe[0] <= 1'b0;
        repeat (2) @(posedge pclk);
        tb_oe[0] <= 1'b1;
        repeat (2) @(posedge pclk);
        tb_oe[0] <= 1'b0;
        wait_done();
        chk(acts.size(), 32'h3, "measure passes");
        chk(pk[0] + pk[1], 32'h2, "source delay pulses");
        chk(pulses[1], 32'h2, "default out line");
    endtask

    task automatic scan_run();
        clr();
        wr(TLH_ADDR_LINES, 32'h0000_0012);
        wr(TLH_ADDR_CFG, 32'h0000_0091);
        wr(TLH_ADDR_COUNT, 32'h0000_000A);
        wr(TLH_ADDR_CTRL, 32'h0000_0001);
        repeat (20) @(posedge pclk);
        chk(cnt(2'h2), 32'h0, "measure before trigger");
        sc_start <= 1'b1;
        @(posedge pclk);
        sc_start <= 1'b0;
        wait_done();
        chk(cnt(2'h2), 32'hA, "measure count");
        chk(pk[2], 32'hA, "pulse after measure");
        chk(pk[0] + pk[1], 32'h0, "pulse after other");
        chk(pulses[0], 32'hA, "pulses on line 1");
        chk(closed, 32'hA, "channels closed");
    endtask

    // Bypass skips only the first source wait; abort parks the loop
    task automatic abort_run();
        clr();
        wr(TLH_ADDR_COUNT, 32'h0000_0000);
        wr(TLH_ADDR_CFG, 32'h0000_001F);
        wr(TLH_ADDR_CTRL, 32'h0000_0001);
        repeat (12) @(posedge pclk);
        chk(acts.size(), 32'h1, "bypass once");
        chk(dut_busy, 32'h1, "busy while waiting");
        wr(TLH_ADDR_CTRL, 32'h0000_0002);
        rd(TLH_ADDR_STATUS, 32'h0001_0000, "abort to idle");
        chk(dut_busy, 32'h0, "idle after abort");
        wr(TLH_ADDR_CFG, 32'h0000_0000);
        wr(TLH_ADDR_CTRL, 32'h0000_0001);
        wait_done();
        chk(acts.size(), 32'h4, "zero count runs once");
        chk(pulses.sum(), 32'h0, "no pulse when disabled");
    endtask

    task automatic stop_test();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        #(40 * 20000);
        error_cnt++;
        stop_test();
    end

    initial
    begin
        {presetn, psel, penable, pwrite, sc_start} = '0;
        {paddr, pwdata, tb_oe} = '0;
        sc_in_idx = 3'h0;
        sc_out_idx = 3'h1;
        error_cnt = 0;
        compares = 0;
        clr();
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(tl_oe, 32'h0, "idle lines");
        reset_regs();
        imm_run();
        detectors();
        scan_run();
        abort_run();
        stop_test();
    end
endmodule // tlh_trigger_link_tb
